// ### logic/eirf_top.v
// Notes on behaviour
// - Eight-bit flag register covers six lines, two groups
// - Low group flag: any port line 0-7
// - High group flag: any port line 8-15
// - One read/write pending flag per external line
// - Edge flag cleared by read-one then write-zero
// - Level flag follows the qualified pin level
// - Software writes never alter level-mode flags
// - Two sense bits: fall, rise, low, high
// - One sense bit per port line: low/high
// - Port line enable bit, reset zero, gates requests
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "eirf_regs.vh"
module eirf_top (
    input  wire                   clk,
    input  wire                   arst_n,
    input  wire [`EIRF_AW-1:0]    reg_addr,
    input  wire [`EIRF_DW-1:0]    reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [`EIRF_DW-1:0]    reg_rdata,
    input  wire [`EIRF_NEXT-1:0]  ext_request_line,
    input  wire [`EIRF_NPORT-1:0] port_request_line,
    output reg                    irq_out
);

    // Sense decode of one external line against current and past level
    function ext_hit;
        input [1:0] sense;
        input       cur;
        input       prev;
        begin
            case (sense)
                `EIRF_SNS_FALL: ext_hit = prev & ~cur;
                `EIRF_SNS_RISE: ext_hit = ~prev & cur;
                `EIRF_SNS_LOW:  ext_hit = ~cur;
                `EIRF_SNS_HIGH: ext_hit = cur;
                default:        ext_hit = 1'b0;
            endcase
        end
    endfunction

    // Level modes have the upper sense bit set
    function is_level;
        input [1:0] sense;
        begin
            is_level = (sense == `EIRF_SNS_LOW) || (sense == `EIRF_SNS_HIGH);
        end
    endfunction

    // Write-one-to-clear merge with set winning over clear
    function [`EIRF_FLAG_W-1:0] w1c_merge;
        input [`EIRF_FLAG_W-1:0] cur;
        input [`EIRF_FLAG_W-1:0] clr;
        input [`EIRF_FLAG_W-1:0] set;
        begin
            w1c_merge = (cur & ~clr) | set;
        end
    endfunction

    // Software-visible control state
    reg  [`EIRF_DW-1:0]     ctl_one_r;
    reg  [`EIRF_DW-1:0]     ctl_two_r;
    reg  [`EIRF_DW-1:0]     port_en_r;
    reg  [`EIRF_FLAG_W-1:0] status_r;
    reg  [`EIRF_FLAG_W-1:0] status_nxt;
    reg  [`EIRF_FLAG_W-1:0] mask_r;

    // External line flags and their clear arming
    reg  [`EIRF_NEXT-1:0]   ext_flag_r;
    reg  [`EIRF_NEXT-1:0]   ext_flag_nxt;
    reg  [`EIRF_NEXT-1:0]   ext_armed_r;
    reg  [`EIRF_NEXT-1:0]   ext_armed_nxt;
    reg  [`EIRF_NEXT-1:0]   ext_prev_r;
    reg  [`EIRF_NEXT-1:0]   ext_hit_v;
    reg  [`EIRF_NEXT-1:0]   ext_lvl_v;

    // Synchronised pins and group flags
    wire [`EIRF_NEXT-1:0]   ext_sync;
    wire [`EIRF_NPORT-1:0]  port_sync;
    wire                    port_group_low_flag;
    wire                    port_group_high_flag;

    // Assembled flag register views
    wire [`EIRF_FLAG_W-1:0] flags_now;
    wire [`EIRF_FLAG_W-1:0] flags_rise;
    reg  [`EIRF_FLAG_W-1:0] flags_prev_r;
    reg  [`EIRF_DW-1:0]     rdata_nxt;

    // Access decodes
    wire wr_flags;
    wire rd_flags;
    wire wr_ctl_one;
    wire wr_ctl_two;
    wire wr_port_en;
    wire wr_status;
    wire wr_mask;

    integer i;
    integer k;

    assign wr_flags   = reg_wr && (reg_addr == `EIRF_OFF_FLAGS);
    assign rd_flags   = reg_rd && (reg_addr == `EIRF_OFF_FLAGS);
    assign wr_ctl_one = reg_wr && (reg_addr == `EIRF_OFF_CTL_ONE);
    assign wr_ctl_two = reg_wr && (reg_addr == `EIRF_OFF_CTL_TWO);
    assign wr_port_en = reg_wr && (reg_addr == `EIRF_OFF_PORT_EN);
    assign wr_status  = reg_wr && (reg_addr == `EIRF_OFF_STATUS);
    assign wr_mask    = reg_wr && (reg_addr == `EIRF_OFF_MASK);

    // Pins cross into the clock domain first
    eirf_sync #(
        .W (`EIRF_NEXT)
    ) u_ext_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .pin_in   (ext_request_line),
        .pin_sync (ext_sync)
    );

    eirf_sync #(
        .W (`EIRF_NPORT)
    ) u_port_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .pin_in   (port_request_line),
        .pin_sync (port_sync)
    );

    // Low group: port lines 0 to 7
    eirf_group u_grp_low (
        .clk        (clk),
        .arst_n     (arst_n),
        .line_sync  (port_sync[`EIRF_NGRP-1:0]),
        .sense_high (ctl_two_r[`EIRF_NGRP-1:0]),
        .line_en    (port_en_r[`EIRF_NGRP-1:0]),
        .group_flag (port_group_low_flag)
    );

    // High group: port lines 8 to 15
    eirf_group u_grp_high (
        .clk        (clk),
        .arst_n     (arst_n),
        .line_sync  (port_sync[`EIRF_NPORT-1:`EIRF_NGRP]),
        .sense_high (ctl_two_r[`EIRF_NPORT-1:`EIRF_NGRP]),
        .line_en    (port_en_r[`EIRF_NPORT-1:`EIRF_NGRP]),
        .group_flag (port_group_high_flag)
    );

    // Previous synchronised level for edge detection
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ext_prev_r <= `EIRF_RST_EXT;
        else
            ext_prev_r <= ext_sync;
    end

    // Per-line detection from its two sense bits
    always @*
    begin
        ext_hit_v = `EIRF_RST_EXT;
        ext_lvl_v = `EIRF_RST_EXT;
        for (k = 0; k < `EIRF_NEXT; k = k + 1)
        begin
            ext_hit_v[k] = ext_hit(ctl_one_r[2*k+1 -: 2], ext_sync[k],
                                   ext_prev_r[k]);
            ext_lvl_v[k] = is_level(ctl_one_r[2*k+1 -: 2]);
        end
    end

    // Flag update: level follows pin, edge latches until cleared
    always @*
    begin
        ext_flag_nxt  = ext_flag_r;
        ext_armed_nxt = ext_armed_r;
        for (i = 0; i < `EIRF_NEXT; i = i + 1)
        begin
            if (ext_lvl_v[i])
            begin
                ext_flag_nxt[i]  = ext_hit_v[i];
                ext_armed_nxt[i] = 1'b0;
            end
            else if (ext_hit_v[i])
            begin
                // New edge wins over a clearing write in the same cycle
                ext_flag_nxt[i]  = 1'b1;
                ext_armed_nxt[i] = ext_armed_r[i] & ~wr_flags;
            end
            else if (wr_flags && ext_armed_r[i] && !reg_wdata[i])
            begin
                ext_flag_nxt[i]  = 1'b0;
                ext_armed_nxt[i] = 1'b0;
            end
            else if (wr_flags)
            begin
                // Writing one or clearing unread keeps the flag but disarms the clear
                ext_armed_nxt[i] = 1'b0;
            end
            // A read that returns one arms the clear of an edge-mode flag
            if (rd_flags && ext_flag_r[i] && !ext_lvl_v[i])
                ext_armed_nxt[i] = 1'b1;
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ext_flag_r  <= `EIRF_RST_EXT;
            ext_armed_r <= `EIRF_RST_EXT;
        end
        else
        begin
            ext_flag_r  <= ext_flag_nxt;
            ext_armed_r <= ext_armed_nxt;
        end
    end

    // Eight-bit flag register layout
    assign flags_now  = {port_group_low_flag, port_group_high_flag,
                         ext_flag_r};
    assign flags_rise = {flags_now[`EIRF_FLG_GLO:`EIRF_FLG_GHI] &
                         ~flags_prev_r[`EIRF_FLG_GLO:`EIRF_FLG_GHI],
                         ext_flag_nxt & ~ext_flag_r};

    // Previous flag view; group flags are registered, so their rise
    // reaches the status one cycle after the flag itself
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            flags_prev_r <= `EIRF_RST_FLAGS;
        else
            flags_prev_r <= flags_now;
    end

    // Sense and enable registers
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctl_one_r <= `EIRF_RST_CTL;
            ctl_two_r <= `EIRF_RST_CTL;
            port_en_r <= `EIRF_RST_CTL;
        end
        else
        begin
            if (wr_ctl_one)
                ctl_one_r <= {{(`EIRF_DW-`EIRF_CTL1_MSB-1){1'b0}},
                              reg_wdata[`EIRF_CTL1_MSB:0]};
            if (wr_ctl_two)
                ctl_two_r <= reg_wdata;
            if (wr_port_en)
                port_en_r <= reg_wdata;
        end
    end

    // Sticky events on each rising flag; set wins over clear
    always @*
    begin
        status_nxt = w1c_merge(status_r,
                               wr_status ? reg_wdata[`EIRF_FLAG_W-1:0]
                                         : `EIRF_RST_FLAGS,
                               flags_rise);
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_r <= `EIRF_RST_FLAGS;
            mask_r   <= `EIRF_RST_FLAGS;
        end
        else
        begin
            status_r <= status_nxt;
            if (wr_mask)
                mask_r <= reg_wdata[`EIRF_FLAG_W-1:0];
        end
    end

    // Level interrupt from unmasked sticky bits
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_out <= 1'b0;
        else if (wr_mask)
            irq_out <= |(status_nxt & reg_wdata[`EIRF_FLAG_W-1:0]);
        else
            irq_out <= |(status_nxt & mask_r);
    end

    // Read mux; unmapped offsets read zero
    always @*
    begin
        rdata_nxt = `EIRF_RST_DATA;
        case (reg_addr)
            `EIRF_OFF_FLAGS:
                rdata_nxt = {{(`EIRF_DW-`EIRF_FLAG_W){1'b0}},
                             flags_now};
            `EIRF_OFF_CTL_ONE:
                rdata_nxt = ctl_one_r;
            `EIRF_OFF_CTL_TWO:
                rdata_nxt = ctl_two_r;
            `EIRF_OFF_PORT_EN:
                rdata_nxt = port_en_r;
            `EIRF_OFF_STATUS:
                rdata_nxt = {{(`EIRF_DW-`EIRF_FLAG_W){1'b0}}, status_r};
            `EIRF_OFF_MASK:
                rdata_nxt = {{(`EIRF_DW-`EIRF_FLAG_W){1'b0}}, mask_r};
            default:
                rdata_nxt = `EIRF_RST_DATA;
        endcase
    end

    // Read data stands for one cycle after the strobe only
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= `EIRF_RST_DATA;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= `EIRF_RST_DATA;
    end

endmodule

// ### logic/eirf_regs.vh
`ifndef EIRF_REGS_VH
`define EIRF_REGS_VH

// Register bus shape
`define EIRF_AW            3
`define EIRF_DW            16

// Register offsets on the plain register port
`define EIRF_OFF_FLAGS     3'h0
`define EIRF_OFF_CTL_ONE   3'h1
`define EIRF_OFF_CTL_TWO   3'h2
`define EIRF_OFF_PORT_EN   3'h3
`define EIRF_OFF_STATUS    3'h4
`define EIRF_OFF_MASK      3'h5

// Line counts
`define EIRF_NEXT          6
`define EIRF_NPORT         16
`define EIRF_NGRP          8
`define EIRF_FLAG_W        8

// Fields of the request flag register
`define EIRF_FLG_EXT_MSB   5
`define EIRF_FLG_GHI       6
`define EIRF_FLG_GLO       7

// Used width of the first control register (two sense bits per line)
`define EIRF_CTL1_MSB      11

// Sense select codes of an external request line
`define EIRF_SNS_FALL      2'h0
`define EIRF_SNS_RISE      2'h1
`define EIRF_SNS_LOW       2'h2
`define EIRF_SNS_HIGH      2'h3

// Reset values
`define EIRF_RST_FLAGS     8'h00
`define EIRF_RST_CTL       16'h0000
`define EIRF_RST_EXT       6'h00
`define EIRF_RST_DATA      16'h0000

`endif

// ### logic/eirf_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser for a bundle of asynchronous pins
module eirf_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] pin_sync
);

    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r   <= {W{1'b0}};
            pin_sync <= {W{1'b0}};
        end
        else
        begin
            meta_r   <= pin_in;
            pin_sync <= meta_r;
        end
    end

endmodule

// ### logic/eirf_group.v
`timescale 1ns/1ns
`include "eirf_regs.vh"
// Any-request flag of one group of eight port request lines
module eirf_group (
    input  wire                     clk,
    input  wire                     arst_n,
    input  wire [`EIRF_NGRP-1:0]    line_sync,
    input  wire [`EIRF_NGRP-1:0]    sense_high,
    input  wire [`EIRF_NGRP-1:0]    line_en,
    output reg                      group_flag
);

    wire [`EIRF_NGRP-1:0] active;

    // Line counts as requesting when its level matches the sense bit
    assign active = line_en & ~(line_sync ^ sense_high);

    // Group flag is the OR of qualified requests
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            group_flag <= 1'b0;
        else
            group_flag <= |active;
    end

endmodule

// ### test/eirf_monitor.sv
`timescale 1ns/1ns
`include "eirf_regs.vh"
module eirf_monitor (
    input wire                   clk,
    input wire                   arst_n,
    input wire [`EIRF_AW-1:0]    reg_addr,
    input wire [`EIRF_DW-1:0]    reg_wdata,
    input wire                   reg_wr,
    input wire                   reg_rd,
    input wire [`EIRF_DW-1:0]    reg_rdata,
    input wire [`EIRF_NEXT-1:0]  ext_request_line,
    input wire [`EIRF_NPORT-1:0] port_request_line,
    input wire                   irq_out
);
    reg [15:0] shd_r [0:7];
    reg [1:0]  lo_off_r;
    reg [1:0]  hi_off_r;
    reg [1:0]  mk_off_r;
    integer    i;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Shadow of written words, counts of cycles with enables off
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (i = 0; i < 8; i = i + 1)
                shd_r[i] <= 16'h0000;
            lo_off_r <= 2'h0;
            hi_off_r <= 2'h0;
            mk_off_r <= 2'h0;
        end
        else
        begin
            if (reg_wr)
                shd_r[reg_addr] <= reg_wdata;
            lo_off_r <= (shd_r[3][7:0] != 8'h00) ? 2'h0 :
                        lo_off_r + (lo_off_r != 2'h3);
            hi_off_r <= (shd_r[3][15:8] != 8'h00) ? 2'h0 :
                        hi_off_r + (hi_off_r != 2'h3);
            mk_off_r <= (shd_r[5][7:0] != 8'h00) ? 2'h0 :
                        mk_off_r + (mk_off_r != 2'h3);
        end
    end
    rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_zero_a:
    assert property ($past(reg_rd && reg_addr >= 3'h6) |->
                     reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    flag_upper_a:
    assert property ($past(reg_rd && reg_addr == 3'h0) |->
                     reg_rdata[15:8] == 8'h00)
        else $error("flag read upper byte not zero");
    sense_rb_a:
    assert property ($past(reg_rd && reg_addr == 3'h1) |->
                     reg_rdata == ($past(shd_r[1]) & 16'h0FFF))
        else $error("sense select readback wrong");
    port_sense_rb_a:
    assert property ($past(reg_rd && reg_addr == 3'h2) |->
                     reg_rdata == $past(shd_r[2]))
        else $error("port sense readback wrong");
    port_en_rb_a:
    assert property ($past(reg_rd && reg_addr == 3'h3) |->
                     reg_rdata == $past(shd_r[3]))
        else $error("port enable readback wrong");
    lo_grp_off_a:
    assert property ($past(reg_rd && reg_addr == 3'h0 && lo_off_r == 2'h3 &&
                           shd_r[3][7:0] == 8'h00) |-> !reg_rdata[7])
        else $error("low group flag with lines disabled");
    hi_grp_off_a:
    assert property ($past(reg_rd && reg_addr == 3'h0 && hi_off_r == 2'h3 &&
                           shd_r[3][15:8] == 8'h00) |-> !reg_rdata[6])
        else $error("high group flag with lines disabled");
    irq_masked_a:
    assert property (mk_off_r == 2'h3 && shd_r[5][7:0] == 8'h00 |-> !irq_out)
        else $error("interrupt raised with all masked");
endmodule
bind eirf_top eirf_monitor u_mon (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_request_line(ext_request_line),
    .port_request_line(port_request_line), .irq_out(irq_out));

// ### test/eirf_pin_model.sv
`timescale 1ns/1ns
// Request pins, changed just after an edge and held a whole cycle
module eirf_pin_model (
    input  wire        clk,
    input  wire [5:0]  ext_cmd,
    input  wire [15:0] port_cmd,
    output reg  [5:0]  ext_request_line,
    output reg  [15:0] port_request_line
);
    // Lines are always driven, never left floating
    initial
    begin
        ext_request_line  = 6'h00;
        port_request_line = 16'h0000;
    end
    always @(posedge clk)
    begin
        ext_request_line  <= ext_cmd;
        port_request_line <= port_cmd;
    end
endmodule

// ### test/tb.sv
`timescale 1ns/1ns
`include "eirf_regs.vh"
module tb;
    typedef struct packed {
        logic [1:0]  code;
        logic        p0;
        logic        p1;
        logic [15:0] sns;
        logic [15:0] en;
        logic [15:0] pins;
        logic [7:0]  exp;
    } eirf_row_t;
    reg         clk;
    reg         arst_n;
    reg  [2:0]  reg_addr;
    reg  [15:0] reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    wire [15:0] reg_rdata;
    reg  [5:0]  ext_cmd;
    reg  [15:0] port_cmd;
    wire [5:0]  ext_request_line;
    wire [15:0] port_request_line;
    wire        irq_out;
    reg  [15:0] rdv;
    int         miscompares;
    int         comparisons;
    // Line 0 sense modes beside group cases
    eirf_row_t rows [0:5] = '{
        '{`EIRF_SNS_FALL, 1'b1, 1'b0, 16'hFFFF, 16'h0000, 16'h0001, 8'h01},
        '{`EIRF_SNS_RISE, 1'b0, 1'b1, 16'hFFFF, 16'h0001, 16'h0001, 8'h81},
        '{`EIRF_SNS_RISE, 1'b1, 1'b0, 16'hFFFF, 16'h8000, 16'h8000, 8'h40},
        '{`EIRF_SNS_LOW,  1'b1, 1'b0, 16'h0000, 16'h0100, 16'h0000, 8'h41},
        '{`EIRF_SNS_HIGH, 1'b0, 1'b1, 16'h0000, 16'h0001, 16'h0001, 8'h01},
        '{`EIRF_SNS_LOW,  1'b0, 1'b1, 16'hFFFF, 16'hFFFF, 16'h0000, 8'h00}};
    eirf_top dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_request_line(ext_request_line),
        .port_request_line(port_request_line), .irq_out(irq_out));
    eirf_pin_model pins (.clk(clk), .ext_cmd(ext_cmd), .port_cmd(port_cmd),
        .ext_request_line(ext_request_line),
        .port_request_line(port_request_line));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task test_done;
    begin
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
    begin
        comparisons++;
        if (got !== exp)
        begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    end
    endtask
    task w(input int n);
    begin
        repeat (n) @(posedge clk);
        #1;
    end
    endtask
    task wr(input [2:0] a, input [15:0] d);
    begin
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    end
    endtask
    task rdc(input [2:0] a, input [15:0] m, input [15:0] e);
    begin
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
        chk(rdv & m, e);
    end
    endtask
    // Read then write zero: clears latched edge flags
    task clear_flags;
    begin
        w(6);
        rdc(`EIRF_OFF_FLAGS, 16'hFF00, 16'h0000);
        wr(`EIRF_OFF_FLAGS, 16'h0000);
    end
    endtask
    // Main sequence
    initial
    begin
        {arst_n, reg_addr, reg_wdata, reg_wr, reg_rd} = 0;
        ext_cmd = 6'h00;
        port_cmd = 16'h0000;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        w(1);
        chk({15'h0000, irq_out}, 16'h0000);
        for (int a = 0; a < 8; a++)
            rdc(a[2:0], 16'hFFFF, 16'h0000);
        foreach (rows[i])
        begin
            ext_cmd[0] <= rows[i].p0;
            port_cmd <= rows[i].pins;
            wr(`EIRF_OFF_CTL_ONE, {14'h0000, rows[i].code});
            wr(`EIRF_OFF_CTL_TWO, rows[i].sns);
            wr(`EIRF_OFF_PORT_EN, rows[i].en);
            clear_flags;
            ext_cmd[0] <= rows[i].p1;
            w(6);
            rdc(`EIRF_OFF_FLAGS, 16'h00C1, {8'h00, rows[i].exp});
        end
        // Edge flag: write zero without read, then read-one/write-zero
        wr(`EIRF_OFF_CTL_ONE, 16'h0004);
        ext_cmd[1] <= 1'b1;
        w(6);
        wr(`EIRF_OFF_FLAGS, 16'h0000);
        rdc(`EIRF_OFF_FLAGS, 16'h0002, 16'h0002);
        wr(`EIRF_OFF_FLAGS, 16'h0000);
        rdc(`EIRF_OFF_FLAGS, 16'h0002, 16'h0000);
        wr(`EIRF_OFF_FLAGS, 16'h00FF);
        rdc(`EIRF_OFF_FLAGS, 16'hFFC2, 16'h0000);
        // Level flag ignores writes and follows the pin
        wr(`EIRF_OFF_CTL_ONE, 16'h0030);
        w(6);
        wr(`EIRF_OFF_FLAGS, 16'h0004);
        rdc(`EIRF_OFF_FLAGS, 16'h0004, 16'h0000);
        ext_cmd[2] <= 1'b1;
        w(6);
        rdc(`EIRF_OFF_FLAGS, 16'h0004, 16'h0004);
        wr(`EIRF_OFF_FLAGS, 16'h0000);
        rdc(`EIRF_OFF_FLAGS, 16'h0004, 16'h0004);
        ext_cmd[2] <= 1'b0;
        w(6);
        rdc(`EIRF_OFF_FLAGS, 16'h0004, 16'h0000);
        // Status, mask and interrupt output
        wr(`EIRF_OFF_MASK, 16'h0001);
        wr(`EIRF_OFF_CTL_ONE, 16'h0001);
        ext_cmd[0] <= 1'b0;
        clear_flags;
        wr(`EIRF_OFF_STATUS, 16'h00FF);
        rdc(`EIRF_OFF_STATUS, 16'hFFFF, 16'h0000);
        ext_cmd[0] <= 1'b1;
        w(6);
        chk({15'h0000, irq_out}, 16'h0001);
        rdc(`EIRF_OFF_STATUS, 16'h0001, 16'h0001);
        wr(`EIRF_OFF_MASK, 16'h0000);
        w(3);
        chk({15'h0000, irq_out}, 16'h0000);
        wr(`EIRF_OFF_MASK, 16'h0001);
        w(3);
        chk({15'h0000, irq_out}, 16'h0001);
        wr(`EIRF_OFF_STATUS, 16'h0001);
        w(3);
        chk({15'h0000, irq_out}, 16'h0000);
        // Readback, reserved bits and unmapped place
        wr(`EIRF_OFF_CTL_ONE, 16'hFFFF);
        rdc(`EIRF_OFF_CTL_ONE, 16'hFFFF, 16'h0FFF);
        wr(`EIRF_OFF_CTL_TWO, 16'hA5A5);
        rdc(`EIRF_OFF_CTL_TWO, 16'hFFFF, 16'hA5A5);
        wr(`EIRF_OFF_PORT_EN, 16'h5A5A);
        rdc(`EIRF_OFF_PORT_EN, 16'hFFFF, 16'h5A5A);
        wr(3'h6, 16'hFFFF);
        rdc(3'h6, 16'hFFFF, 16'h0000);
        // Reset in mid-run: flags, enables and interrupt return to zero
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        w(6);
        chk({15'h0000, irq_out}, 16'h0000);
        rdc(`EIRF_OFF_FLAGS, 16'hFFFF, 16'h0000);
        rdc(`EIRF_OFF_PORT_EN, 16'hFFFF, 16'h0000);
        // A requesting low group line raises its status bit
        wr(`EIRF_OFF_PORT_EN, 16'h0001);
        w(3);
        rdc(`EIRF_OFF_STATUS, 16'h00C0, 16'h0080);
        test_done;
    end
    // Hang guard
    initial
    begin
        #2000000;
        miscompares++;
        test_done;
    end
endmodule
